// File: hdl/cswdt_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cswdt_pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinLevel,
  output logic [WIDTH-1:0] pinRise
);
  for (genvar i = 0; i < WIDTH; i++) begin : gSync
    logic metaR;
    logic levelR;
    logic prevR;
    // the first stage feeds only the second, edge detect sits after it
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        metaR <= 1'b0;
        levelR <= 1'b0;
        prevR <= 1'b0;
      end else begin
        metaR <= pinIn[i];
        levelR <= metaR;
        prevR <= levelR;
      end
    end
    assign pinLevel[i] = levelR;
    assign pinRise[i] = levelR & ~prevR;
  end
endmodule : cswdt_pin_sync
`default_nettype wire

// File: hdl/cswdt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "cswdt_params.svh"
module cswdt_prescaler #(
  parameter int unsigned UNIT_CYCLES = `CSWDT_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  cswdt_tick_if.prescaler tb
);
  import cswdt_pkg::*;
  logic [31:0] cntR;
  logic [31:0] cntNxt;
  logic [31:0] limit;
  logic tickC;

  always_comb begin
    limit = 32'(UNIT_CYCLES);
    if (tb.minuteMode) begin
      limit = 32'(UNIT_CYCLES * `CSWDT_MINUTE_MULT);
    end
    if (tb.fastMode) begin
      limit = limit / `CSWDT_FAST_DIV;
    end
    if (limit == 32'h0) begin
      limit = 32'h1;
    end
    cntNxt = cntR;
    tickC = 1'b0;
    // a fresh load always gets a full first unit
    if (tb.restart || !tb.enable) begin
      cntNxt = 32'h0;
    end else if (cntR >= limit - 32'h1) begin
      cntNxt = 32'h0;
      tickC = 1'b1;
    end else begin
      cntNxt = cntR + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cntR <= 32'h0;
    end else begin
      cntR <= cntNxt;
    end
  end

  assign tb.tick = tickC;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_unit;
    tickC |-> tb.enable && !tb.restart && cntR == limit - 32'h1;
  endproperty
  a_unit: assert property (p_unit) else $error("tick off the unit boundary");

  property p_mode;
    tb.fastMode && !tb.minuteMode && UNIT_CYCLES >= 1000
      |-> limit == 32'(UNIT_CYCLES) / `CSWDT_FAST_DIV;
  endproperty
  a_mode: assert property (p_mode) else $error("fast second unit wrong");
endmodule : cswdt_prescaler
`default_nettype wire

// File: hdl/cswdt_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cswdt_params.svh"
// Operation
// - non-zero count write loads and starts; zero disables
// - count read returns live remaining count
// - one count is about one second in seconds mode
// - ctrl bits 7,6 set: kb/mouse event reloads
// - ctrl bit 5 forces event, self-clearing
// - status bit 4: 0 running, 1 timeout, write-0 clears
// - ctrl bits 3:0 pick the irq line
// - bus reset or power-good restore 04h / 10h
// - mode bit 3 selects seconds or minutes
// - mode bit 4 counts one thousand times faster
module cswdt_top #(
  parameter int unsigned UNIT_CYCLES = `CSWDT_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`CSWDT_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire cswdt_pkg::cswdt_word_t writedata,
  input wire logic [3:0] byteenable,
  output cswdt_pkg::cswdt_word_t readdata,
  output logic waitrequest,
  input wire logic bus_reset_n,
  input wire logic power_good,
  input wire logic keyboardIrq,
  input wire logic mouseIrq,
  output logic [15:0] irqLines,
  output logic irq
);
  import cswdt_pkg::*;

  logic [3:0] pinLevel;
  logic [3:0] pinRise;
  logic regClear;
  logic kbmsEvent;

  cswdt_pin_sync #(.WIDTH(4)) uSync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn({power_good, bus_reset_n, mouseIrq, keyboardIrq}),
    .pinLevel(pinLevel),
    .pinRise(pinRise)
  );

  // mode, count, ctrl and load registers stay at their reset values until both reset pins have synchronised high
  assign regClear = ~pinLevel[2] | ~pinLevel[3];
  assign kbmsEvent = pinRise[0] | pinRise[1];

  cswdt_tick_if tickBus ();

  cswdt_prescaler #(.UNIT_CYCLES(UNIT_CYCLES)) uPre (
    .clk(clk),
    .rst_n(rst_n),
    .tb(tickBus.prescaler)
  );

  // bus slave: one wait state, read data captured on the first cycle
  cswdt_bus_t busR;
  cswdt_bus_t busNxt;
  cswdt_word_t readdataR;
  cswdt_word_t readdataNxt;
  logic accessing;
  logic commit;
  logic wrCommit;
  cswdt_byte_t idx;
  cswdt_byte_t wd;
  logic selMode;
  logic selCount;
  logic selCtrl;
  logic selIstat;
  logic selImask;

  cswdt_byte_t modeR;
  cswdt_byte_t modeNxt;
  cswdt_byte_t countR;
  cswdt_byte_t countNxt;
  cswdt_byte_t loadR;
  cswdt_byte_t loadNxt;
  cswdt_byte_t ctrlR;
  cswdt_byte_t ctrlNxt;
  logic runR;
  logic runNxt;
  logic [1:0] istatR;
  logic [1:0] istatNxt;
  logic [1:0] imaskR;
  logic [1:0] imaskNxt;

  logic loadWr;
  logic zeroWr;
  logic trigWr;
  logic reload;
  logic expire;
  logic timeoutEv;

  assign accessing = read | write;
  assign waitrequest = accessing & (busR == BUS_IDLE);
  assign commit = accessing & (busR == BUS_DONE);
  assign wrCommit = write & commit & byteenable[0];
  assign idx = address[`CSWDT_ADDR_W-1:2];
  assign wd = writedata[7:0];
  assign selMode = idx == `CSWDT_IDX_MODE;
  assign selCount = idx == `CSWDT_IDX_COUNT;
  assign selCtrl = idx == `CSWDT_IDX_CTRL;
  assign selIstat = idx == `CSWDT_IDX_ISTAT;
  assign selImask = idx == `CSWDT_IDX_IMASK;

  always_comb begin
    busNxt = BUS_IDLE;
    readdataNxt = readdataR;
    if (busR == BUS_IDLE && accessing) begin
      busNxt = BUS_DONE;
      readdataNxt = '0;
      if (read) begin
        unique case (1'b1)
          selMode: readdataNxt[7:0] = modeR;
          selCount: readdataNxt[7:0] = countR;
          selCtrl: readdataNxt[7:0] = ctrlR;
          selIstat: readdataNxt[1:0] = istatR;
          selImask: readdataNxt[1:0] = imaskR;
          default: readdataNxt = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busR <= BUS_IDLE;
      readdataR <= '0;
    end else begin
      busR <= busNxt;
      readdataR <= readdataNxt;
    end
  end

  assign readdata = readdataR;

  // watchdog events
  assign loadWr = wrCommit & selCount & (wd != 8'h00);
  assign zeroWr = wrCommit & selCount & (wd == 8'h00);
  assign trigWr = wrCommit & selCtrl & wd[`CSWDT_CTRL_TRIG];
  assign reload = kbmsEvent & ctrlR[`CSWDT_CTRL_KB] & ctrlR[`CSWDT_CTRL_MS]
    & (loadR != 8'h00) & ~loadWr & ~zeroWr & ~regClear;
  assign expire = runR & tickBus.tick & (countR == 8'h01) & ~loadWr & ~zeroWr & ~reload;
  assign timeoutEv = (expire | trigWr) & ~regClear;

  assign tickBus.restart = loadWr | reload;
  assign tickBus.enable = runR;
  assign tickBus.minuteMode = modeR[`CSWDT_MODE_MIN];
  assign tickBus.fastMode = modeR[`CSWDT_MODE_FAST];

  always_comb begin
    modeNxt = modeR;
    countNxt = countR;
    loadNxt = loadR;
    ctrlNxt = ctrlR;
    runNxt = runR;
    istatNxt = istatR;
    imaskNxt = imaskR;
    if (runR && tickBus.tick) begin
      countNxt = countR - 8'h01;
    end
    if (expire) begin
      runNxt = 1'b0;
    end
    if (reload) begin
      countNxt = loadR;
      runNxt = 1'b1;
      ctrlNxt[`CSWDT_CTRL_STAT] = 1'b0;
    end
    if (loadWr) begin
      countNxt = wd;
      loadNxt = wd;
      runNxt = 1'b1;
      ctrlNxt[`CSWDT_CTRL_STAT] = 1'b0;
    end
    if (zeroWr) begin
      countNxt = 8'h00;
      runNxt = 1'b0;
    end
    if (wrCommit && selMode) begin
      modeNxt = '0;
      modeNxt[`CSWDT_MODE_FAST] = wd[`CSWDT_MODE_FAST];
      modeNxt[`CSWDT_MODE_MIN] = wd[`CSWDT_MODE_MIN];
    end
    if (wrCommit && selCtrl) begin
      ctrlNxt[7:6] = wd[7:6];
      ctrlNxt[3:0] = wd[3:0];
      if (!wd[`CSWDT_CTRL_STAT]) begin
        ctrlNxt[`CSWDT_CTRL_STAT] = 1'b0;
      end
    end
    if (trigWr) begin
      runNxt = 1'b0;
    end
    // a timeout in the clearing cycle still lands
    if (timeoutEv) begin
      ctrlNxt[`CSWDT_CTRL_STAT] = 1'b1;
    end
    ctrlNxt[`CSWDT_CTRL_TRIG] = 1'b0;
    if (wrCommit && selIstat) begin
      istatNxt = istatR & ~writedata[1:0];
    end
    if (wrCommit && selImask) begin
      imaskNxt = writedata[1:0];
    end
    istatNxt[`CSWDT_IST_TIMEOUT] = istatNxt[`CSWDT_IST_TIMEOUT] | timeoutEv;
    istatNxt[`CSWDT_IST_RELOAD] = istatNxt[`CSWDT_IST_RELOAD] | reload;
    if (regClear) begin
      modeNxt = `CSWDT_MODE_RST;
      countNxt = `CSWDT_COUNT_RST;
      ctrlNxt = `CSWDT_CTRL_RST;
      loadNxt = `CSWDT_LOAD_RST;
      runNxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeR <= `CSWDT_MODE_RST;
      countR <= `CSWDT_COUNT_RST;
      loadR <= `CSWDT_LOAD_RST;
      ctrlR <= `CSWDT_CTRL_RST;
      runR <= 1'b0;
      istatR <= `CSWDT_ISTAT_RST;
      imaskR <= `CSWDT_IMASK_RST;
    end else begin
      modeR <= modeNxt;
      countR <= countNxt;
      loadR <= loadNxt;
      ctrlR <= ctrlNxt;
      runR <= runNxt;
      istatR <= istatNxt;
      imaskR <= imaskNxt;
    end
  end

  // selector 0 means no line; the status level holds the line until cleared
  for (genvar i = 0; i < 16; i++) begin : gIrq
    assign irqLines[i] = ctrlR[`CSWDT_CTRL_STAT] && (ctrlR[3:0] == 4'(i)) && (i != 0);
  end

  assign irq = |(istatR & imaskR);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_load;
    loadWr && !regClear |=> runR && countR == $past(wd) && loadR == $past(wd);
  endproperty
  a_load: assert property (p_load) else $error("non-zero write did not load");

  property p_zero;
    zeroWr && !regClear |=> !runR && countR == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("zero write left counter running");

  property p_read;
    busR == BUS_IDLE && read && selCount |=> waitrequest == 1'b0 && readdata[7:0] == $past(countR);
  endproperty
  a_read: assert property (p_read) else $error("count read not live");

  property p_reload;
    reload && !trigWr |=> runR && countR == $past(loadR) && !ctrlR[`CSWDT_CTRL_STAT];
  endproperty
  a_reload: assert property (p_reload) else $error("kb or mouse reload missed");

  sequence s_trig;
    trigWr && !regClear;
  endsequence
  sequence s_fired;
    ctrlR[`CSWDT_CTRL_STAT] && !ctrlR[`CSWDT_CTRL_TRIG] && istatR[`CSWDT_IST_TIMEOUT] && !runR;
  endsequence
  property p_trig;
    s_trig |=> s_fired;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not fire");

  property p_run_status;
    runR |-> !ctrlR[`CSWDT_CTRL_STAT];
  endproperty
  a_run_status: assert property (p_run_status) else $error("status set while running");

  property p_irqsel;
    ctrlR[`CSWDT_CTRL_STAT] && ctrlR[3:0] != 4'h0 |-> irqLines == (16'h0001 << ctrlR[3:0]);
  endproperty
  a_irqsel: assert property (p_irqsel) else $error("wrong irq line");

  property p_reset;
    regClear |=> countR == `CSWDT_COUNT_RST && ctrlR == `CSWDT_CTRL_RST && !runR;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");

  sequence s_last;
    expire && !regClear;
  endsequence
  sequence s_stopped;
    !runR && countR == 8'h00 && ctrlR[`CSWDT_CTRL_STAT];
  endsequence
  property p_expire;
    s_last |=> s_stopped ##1 (runR || countR == 8'h00 || $past(regClear) || regClear);
  endproperty
  a_expire: assert property (p_expire) else $error("expiry did not stop");

  property p_no_line;
    irqLines != 16'h0000 |-> ctrlR[`CSWDT_CTRL_STAT] && ctrlR[3:0] != 4'h0;
  endproperty
  a_no_line: assert property (p_no_line) else $error("line with selector zero");

  property p_one_line;
    $onehot0(irqLines);
  endproperty
  a_one_line: assert property (p_one_line) else $error("more than one irq line");

  property p_status_clear;
    wrCommit && selCtrl && !wd[`CSWDT_CTRL_STAT] && !timeoutEv && !regClear
      |=> !ctrlR[`CSWDT_CTRL_STAT];
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

  property p_status_hold;
    ctrlR[`CSWDT_CTRL_STAT] && !(wrCommit && selCtrl) && !loadWr && !reload
      |=> ctrlR[`CSWDT_CTRL_STAT];
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status dropped");

  property p_count_down;
    runR && tickBus.tick && !loadWr && !zeroWr && !reload && !trigWr && !regClear
      |=> countR == $past(countR) - 8'h01;
  endproperty
  a_count_down: assert property (p_count_down) else $error("tick did not decrement");

  property p_count_hold;
    !runR && !loadWr && !zeroWr && !reload && !regClear |=> countR == $past(countR);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("stopped counter moved");

  property p_clear_rest;
    regClear |=> modeR == `CSWDT_MODE_RST && loadR == `CSWDT_LOAD_RST;
  endproperty
  a_clear_rest: assert property (p_clear_rest) else $error("pin reset missed mode");

  property p_istat_set;
    timeoutEv |=> istatR[`CSWDT_IST_TIMEOUT];
  endproperty
  a_istat_set: assert property (p_istat_set) else $error("timeout not latched");
endmodule : cswdt_top
`default_nettype wire

// File: pkg/cswdt_params.svh
`ifndef CSWDT_PARAMS_SVH
`define CSWDT_PARAMS_SVH

`define CSWDT_ADDR_W 10
`define CSWDT_IDX_MODE 8'hF0
`define CSWDT_IDX_COUNT 8'hF1
`define CSWDT_IDX_CTRL 8'hF2
`define CSWDT_IDX_ISTAT 8'hF8
`define CSWDT_IDX_IMASK 8'hF9

`define CSWDT_MODE_RST 8'h00
`define CSWDT_COUNT_RST 8'h04
`define CSWDT_CTRL_RST 8'h10
`define CSWDT_LOAD_RST 8'h00
`define CSWDT_ISTAT_RST 2'h0
`define CSWDT_IMASK_RST 2'h0

`define CSWDT_MODE_FAST 4
`define CSWDT_MODE_MIN 3
`define CSWDT_CTRL_KB 7
`define CSWDT_CTRL_MS 6
`define CSWDT_CTRL_TRIG 5
`define CSWDT_CTRL_STAT 4
`define CSWDT_IST_TIMEOUT 0
`define CSWDT_IST_RELOAD 1

`define CSWDT_CLK_NS 32'd100
`define CSWDT_UNIT_NS 32'd1046000000
`define CSWDT_UNIT_CYCLES (`CSWDT_UNIT_NS / `CSWDT_CLK_NS)
`define CSWDT_MINUTE_MULT 32'd60
`define CSWDT_FAST_DIV 32'd1000

`endif

// File: pkg/cswdt_pkg.sv
`default_nettype none
package cswdt_pkg;
  typedef logic [31:0] cswdt_word_t;
  typedef logic [7:0] cswdt_byte_t;
  typedef enum logic {BUS_IDLE, BUS_DONE} cswdt_bus_t;
endpackage : cswdt_pkg
`default_nettype wire

// File: pkg/cswdt_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cswdt_tick_if;
  logic restart;
  logic enable;
  logic minuteMode;
  logic fastMode;
  logic tick;
  modport prescaler (input restart, input enable, input minuteMode, input fastMode, output tick);
  modport core (output restart, output enable, output minuteMode, output fastMode, input tick);
endinterface : cswdt_tick_if
`default_nettype wire

// File: tb/test_config_space_watchdog_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cswdt_params.svh"
module test_config_space_watchdog_timer;
  import cswdt_pkg::*;
  // short unit keeps the run brief; fast mode then ticks every 2 cycles
  localparam int unsigned UNIT = 2000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  cswdt_word_t writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  cswdt_word_t readdata;
  logic waitrequest;
  logic bus_reset_n = 1'b1;
  logic power_good = 1'b1;
  logic keyboardIrq = 1'b0;
  logic mouseIrq = 1'b0;
  logic [15:0] irqLines;
  logic irq;
  int errors = 0;
  int checks = 0;
  int seed = 8569;
  cswdt_word_t rd;
  int v;

  cswdt_top #(.UNIT_CYCLES(UNIT)) dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .bus_reset_n(bus_reset_n),
    .power_good(power_good),
    .keyboardIrq(keyboardIrq),
    .mouseIrq(mouseIrq),
    .irqLines(irqLines),
    .irq(irq)
  );

  always #50 clk = ~clk;

  task automatic chk(input cswdt_word_t got, input cswdt_word_t exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // the answer is taken at the rising edge where waitrequest is seen low, then released
  task automatic xfer(input logic isWr, input logic [7:0] idx, input cswdt_word_t d);
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= d;
    write <= isWr;
    read <= !isWr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input cswdt_word_t d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input cswdt_word_t exp);
    xfer(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic pins(input logic [15:0] lines, input logic lvl);
    @(negedge clk);
    chk({16'h0000, irqLines}, {16'h0000, lines});
    chk({31'h0, irq}, {31'h0, lvl});
  endtask : pins

  task automatic pulse(input logic mouse);
    @(posedge clk);
    if (mouse) mouseIrq <= 1'b1;
    else keyboardIrq <= 1'b1;
    repeat (3) @(posedge clk);
    mouseIrq <= 1'b0;
    keyboardIrq <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : pulse

  task automatic pinRst(input logic pg);
    @(posedge clk);
    if (pg) power_good <= 1'b0;
    else bus_reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    power_good <= 1'b1;
    bus_reset_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : pinRst

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    wrap_up;
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rdc(`CSWDT_IDX_COUNT, 32'h04);
    rdc(`CSWDT_IDX_CTRL, 32'h10);
    rdc(`CSWDT_IDX_MODE, 32'h00);
    rdc(8'h10, 32'h00);
    pins(16'h0000, 1'b0);
    wr(`CSWDT_IDX_IMASK, 32'h1);
    wr(`CSWDT_IDX_COUNT, 32'h03);
    rdc(`CSWDT_IDX_COUNT, 32'h03);
    rdc(`CSWDT_IDX_CTRL, 32'h00);
    repeat (UNIT) @(posedge clk);
    rdc(`CSWDT_IDX_COUNT, 32'h02);
    wr(`CSWDT_IDX_CTRL, 32'h05);
    repeat (2 * UNIT + 50) @(posedge clk);
    rdc(`CSWDT_IDX_COUNT, 32'h00);
    rdc(`CSWDT_IDX_CTRL, 32'h15);
    pins(16'h0020, 1'b1);
    rdc(`CSWDT_IDX_ISTAT, 32'h01);
    wr(`CSWDT_IDX_ISTAT, 32'h1);
    pins(16'h0020, 1'b0);
    wr(`CSWDT_IDX_CTRL, 32'h05);
    pins(16'h0000, 1'b0);
    wr(`CSWDT_IDX_IMASK, 32'h0);
    // every selector code, via the software trigger
    for (int s = 0; s < 16; s++) begin
      wr(`CSWDT_IDX_CTRL, 32'h20 | s);
      pins((s == 0) ? 16'h0000 : (16'h0001 << s), 1'b0);
      rdc(`CSWDT_IDX_CTRL, 32'h10 | s);
      wr(`CSWDT_IDX_CTRL, s);
      wr(`CSWDT_IDX_ISTAT, 32'h1);
    end
    wr(`CSWDT_IDX_MODE, 32'h10);
    repeat (4) begin
      wr(`CSWDT_IDX_CTRL, 32'h00);
      v = 40 + ({$random(seed)} % 200);
      wr(`CSWDT_IDX_COUNT, v);
      repeat (2 * v - 30) @(posedge clk);
      rdc(`CSWDT_IDX_CTRL, 32'h00);
      repeat (60) @(posedge clk);
      rdc(`CSWDT_IDX_COUNT, 32'h00);
      rdc(`CSWDT_IDX_CTRL, 32'h10);
    end
    wr(`CSWDT_IDX_MODE, 32'h18);
    wr(`CSWDT_IDX_COUNT, 32'h03);
    repeat (200) @(posedge clk);
    rdc(`CSWDT_IDX_COUNT, 32'h02);
    wr(`CSWDT_IDX_ISTAT, 32'h3);
    wr(`CSWDT_IDX_CTRL, 32'hC0);
    wr(`CSWDT_IDX_COUNT, 32'h05);
    repeat (250) @(posedge clk);
    rdc(`CSWDT_IDX_COUNT, 32'h03);
    pulse(1'b0);
    rdc(`CSWDT_IDX_COUNT, 32'h05);
    rdc(`CSWDT_IDX_ISTAT, 32'h02);
    repeat (250) @(posedge clk);
    pulse(1'b1);
    rdc(`CSWDT_IDX_COUNT, 32'h05);
    repeat (250) @(posedge clk);
    wr(`CSWDT_IDX_CTRL, 32'h80);
    pulse(1'b0);
    rdc(`CSWDT_IDX_COUNT, 32'h03);
    wr(`CSWDT_IDX_COUNT, 32'h00);
    repeat (300) @(posedge clk);
    rdc(`CSWDT_IDX_COUNT, 32'h00);
    rdc(`CSWDT_IDX_CTRL, 32'h80);
    // a write without its low byte lane must leave the count alone
    byteenable <= 4'hE;
    wr(`CSWDT_IDX_COUNT, 32'h07);
    byteenable <= 4'hF;
    rdc(`CSWDT_IDX_COUNT, 32'h00);
    wr(`CSWDT_IDX_COUNT, 32'h09);
    pinRst(1'b0);
    rdc(`CSWDT_IDX_COUNT, 32'h04);
    rdc(`CSWDT_IDX_CTRL, 32'h10);
    rdc(`CSWDT_IDX_MODE, 32'h00);
    wr(`CSWDT_IDX_COUNT, 32'h09);
    wr(`CSWDT_IDX_CTRL, 32'h03);
    pinRst(1'b1);
    rdc(`CSWDT_IDX_COUNT, 32'h04);
    rdc(`CSWDT_IDX_CTRL, 32'h10);
    wrap_up;
  end
endmodule : test_config_space_watchdog_timer
`default_nettype wire
